// >>> bench/dct_event_src.sv
// Purpose: drives the event pins and gate inputs of the timer unit
// Assumes: called right after a rising clock edge
// Notes:   pins idle high
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module dct_event_src (
    input  wire logic clk_in,  // clock
    output logic      ev0_out, // event pin 0
    output logic      ev1_out, // event pin 1
    output logic      g0_out,  // gate input 0
    output logic      g1_out   // gate input 1
);
    initial begin
        ev0_out = 1'b1;
        ev1_out = 1'b1;
        g0_out  = 1'b0;
        g1_out  = 1'b0;
    end
    // each level held two clocks, fastest legal event rate
    task automatic pulses(input int ch, input int n);
        repeat (n) begin
            if (ch == 0) ev0_out <= 1'b0; else ev1_out <= 1'b0;
            repeat (2) @(posedge clk_in);
            if (ch == 0) ev0_out <= 1'b1; else ev1_out <= 1'b1;
            repeat (2) @(posedge clk_in);
        end
    endtask : pulses
    task automatic set_gates(input logic a, input logic b);
        g0_out <= a;
        g1_out <= b;
    endtask : set_gates
endmodule : dct_event_src

// >>> bench/dct_timer_unit_props.sv
// Purpose: bus and interrupt checks on the timer unit ports
// Assumes: one clock domain, reset active low
// Notes:   bound to the design from tb
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module dct_timer_unit_props (
    input wire logic        clk_in,     // clock
    input wire logic        rst_b_in,   // reset, low
    input wire logic        wb_cyc_in,  // bus cycle
    input wire logic        wb_stb_in,  // strobe
    input wire logic        wb_we_in,   // write enable
    input wire logic [7:0]  wb_adr_in,  // address
    input wire logic [3:0]  wb_sel_in,  // byte selects
    input wire logic [31:0] wb_dat_in,  // write data
    input wire logic [31:0] wb_dat_out, // read data
    input wire logic        wb_ack_out, // acknowledge
    input wire logic        irq_out     // interrupt
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence req_s;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    sequence mask_off_s;
        req_s ##0 (wb_we_in && wb_sel_in[0] && wb_adr_in == 8'h20 && wb_dat_in[1:0] == 2'h0);
    endsequence
    a_ack_next: assert property (req_s |=> wb_ack_out)
        else $error("ack missing after request");
    a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
        else $error("ack without request");
    a_dat_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
        else $error("read data outside ack");
    a_dat_upper: assert property (wb_dat_out[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_unmapped_zero: assert property (req_s ##0 (!wb_we_in && wb_adr_in == 8'h30)
        |=> wb_dat_out == 32'h0)
        else $error("unmapped read not zero");
    a_irq_masked: assert property (mask_off_s |-> ##3 !irq_out [*3])
        else $error("irq high with mask cleared");
    a_reset_quiet: assert property ($rose(rst_b_in) |-> !wb_ack_out
        ##1 (!wb_ack_out && !irq_out))
        else $error("output active after reset");
endmodule : dct_timer_unit_props

// >>> bench/tb.sv
// Purpose: self-checking bench of the dual counter/timer unit
// Assumes: 50 MHz clock, wishbone classic master
// Notes:   reads are noted in a queue and checked at ack
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb;
    typedef struct { logic [7:0] adr; logic [7:0] val; logic [7:0] msk; } dct_note_s;
    logic        clk, rst_b, cyc, stb, we, ack, irq, ovf0, ovf1, ev0, ev1, g0, g1;
    logic [7:0]  adr, r;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    dct_note_s   exp_q[$];
    dct_note_s   e;
    int          bad_count, num_checks, i, seed, n_ov0;
    dct_timer_unit dct_timer_unit_i (.clk_in(clk), .rst_b_in(rst_b), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .timer_zero_event_pin_in(ev0),
        .timer_one_event_pin_in(ev1), .gate_zero_input_in(g0), .gate_one_input_in(g1),
        .irq_out(irq), .t0_ovf_out(ovf0), .t1_ovf_out(ovf1));
    dct_event_src dct_event_src_i (.clk_in(clk), .ev0_out(ev0), .ev1_out(ev1),
        .g0_out(g0), .g1_out(g1));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : acc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
        exp_q.push_back('{a, v, m});
        acc(1'b0, a, 8'h00);
    endtask : rd
    task automatic chk(input string n, input logic v, input logic g);
        num_checks++;
        if (g !== v) begin
            bad_count++;
            $display("unexpected %s: exp %b got %b", n, v, g);
        end
    endtask : chk
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            num_checks++;
            if (exp_q.size() == 0) begin
                bad_count++;
                $display("unexpected read: exp none got %h", rdat[7:0]);
            end else begin
                e = exp_q.pop_front();
                if ((rdat[7:0] & e.msk) !== e.val) begin
                    bad_count++;
                    $display("unexpected reg %h: exp %h got %h", e.adr, e.val, rdat[7:0] & e.msk);
                end
            end
        end
    end
    // one count per cycle of the timer zero wrap pulse
    always @(posedge clk) begin
        if (ovf0 === 1'b1) n_ov0++;
    end
    initial begin
        tick(20000);
        bad_count++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h1fb43364;
        {cyc, stb, we, adr, wdat} = '0;
        sel   = 4'hF;
        rst_b = 1'b0;
        tick(20);
        rst_b <= 1'b1;
        tick(3);
        for (i = 0; i <= 'h30; i += 4) rd(i[7:0], 8'h00, 8'hFF);
        r = 8'($random(seed));
        wr(8'h08, r);
        wr(8'h0C, ~r);
        rd(8'h08, r, 8'hFF);
        rd(8'h0C, ~r, 8'hFF);
        // 16-bit event count across the wrap, interrupt raised and cleared
        wr(8'h14, 8'h05);
        wr(8'h0C, 8'h00);
        wr(8'h00, 8'hFE);
        wr(8'h04, 8'hFF);
        wr(8'h20, 8'h01);
        wr(8'h10, 8'h01);
        rd(8'h00, 8'hFE, 8'hFF);
        dct_event_src_i.pulses(0, 3);
        tick(6);
        rd(8'h00, 8'h01, 8'hFF);
        rd(8'h04, 8'h00, 8'hFF);
        rd(8'h10, 8'h03, 8'hFF);
        chk("irq_set", 1'b1, irq);
        rd(8'h24, 8'h01, 8'h01);
        tick(2);
        chk("irq_clear", 1'b0, irq);
        // 13-bit wrap from all ones
        wr(8'h10, 8'h00);
        wr(8'h14, 8'h04);
        wr(8'h04, 8'hFF);
        wr(8'h00, 8'h1F);
        wr(8'h10, 8'h01);
        dct_event_src_i.pulses(0, 1);
        tick(6);
        rd(8'h00, 8'h00, 8'h1F);
        rd(8'h04, 8'h00, 8'hFF);
        rd(8'h10, 8'h03, 8'hFF);
        // auto-reload from the high byte
        wr(8'h10, 8'h00);
        wr(8'h14, 8'h06);
        wr(8'h04, 8'hA0);
        wr(8'h00, 8'hFF);
        wr(8'h10, 8'h01);
        dct_event_src_i.pulses(0, 2);
        tick(6);
        rd(8'h00, 8'hA1, 8'hFF);
        rd(8'h04, 8'hA0, 8'hFF);
        // timer one gated by the second input and its polarity
        wr(8'h10, 8'h00);
        wr(8'h14, 8'hD6);
        wr(8'h1C, 8'h02);
        wr(8'h08, 8'h10);
        wr(8'h10, 8'h04);
        dct_event_src_i.pulses(1, 2);
        tick(6);
        rd(8'h08, 8'h10, 8'hFF);
        dct_event_src_i.set_gates(1'b0, 1'b1);
        tick(4);
        dct_event_src_i.pulses(1, 2);
        tick(6);
        rd(8'h08, 8'h12, 8'hFF);
        wr(8'h1C, 8'h00);
        tick(4);
        dct_event_src_i.pulses(1, 1);
        tick(6);
        rd(8'h08, 8'h12, 8'hFF);
        // split mode: low byte on events, high byte on the clock
        wr(8'h10, 8'h00);
        wr(8'h14, 8'h37);
        wr(8'h18, 8'h02);
        wr(8'h04, 8'hF0);
        wr(8'h00, 8'hFE);
        wr(8'h10, 8'h05);
        dct_event_src_i.pulses(0, 2);
        tick(300);
        rd(8'h00, 8'h00, 8'hFF);
        rd(8'h10, 8'h0A, 8'h0A);
        wr(8'h08, 8'h55);
        tick(10);
        rd(8'h08, 8'h55, 8'hFF);
        wr(8'h10, 8'h01);
        wr(8'h0C, 8'hFF);
        wr(8'h14, 8'h27);
        for (i = 0; i < 600 && ovf1 !== 1'b1; i++) @(posedge clk);
        chk("t1_ovf", 1'b1, ovf1);
        rd(8'h10, 8'h00, 8'h08);
        // 16-bit timer on the divide-by-4 prescaler: 403 run edges give 100 or 101
        wr(8'h10, 8'h00);
        wr(8'h14, 8'h01);
        wr(8'h18, 8'h04);
        wr(8'h00, 8'h00);
        wr(8'h04, 8'h00);
        wr(8'h10, 8'h01);
        tick(400);
        wr(8'h10, 8'h00);
        rd(8'h00, 8'h64, 8'hFE);
        rd(8'h04, 8'h00, 8'hFF);
        wr(8'h20, 8'h00);
        tick(6);
        // one wrap each in 16-bit, 13-bit, auto-reload and split low byte
        num_checks++;
        if (n_ov0 != 4) begin
            bad_count++;
            $display("unexpected t0_ovf count: exp 4 got %0d", n_ov0);
        end
        summarize();
    end
endmodule : tb
bind dct_timer_unit dct_timer_unit_props dct_timer_unit_props_i (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .irq_out(irq_out));

// >>> core/dct_consts.svh
// Purpose: offsets, field positions, reset values and counts of the timer unit
// Assumes: 32-bit wishbone words, 8-bit registers in the low byte lane
// Notes:   included by core/dct_timer_unit.sv
`ifndef DCT_CONSTS_SVH
`define DCT_CONSTS_SVH

// register byte addresses
`define DCT_A_T0LO  8'h00
`define DCT_A_T0HI  8'h04
`define DCT_A_T1LO  8'h08
`define DCT_A_T1HI  8'h0C
`define DCT_A_RUN   8'h10
`define DCT_A_MODE  8'h14
`define DCT_A_CLK   8'h18
`define DCT_A_GCFG  8'h1C
`define DCT_A_IEN   8'h20
`define DCT_A_ISTAT 8'h24

// run/flag register fields
`define DCT_B_RUN0  0
`define DCT_B_OVF0  1
`define DCT_B_RUN1  2
`define DCT_B_OVF1  3

// clock control fields
`define DCT_B_CKS0  0
`define DCT_B_CKS1  1
`define DCT_B_PSLO  2

// prescaler divide values per prescale select code
`define DCT_DIV0    6'h0C
`define DCT_DIV1    6'h04
`define DCT_DIV2    6'h30
`define DCT_DIV3    6'h08

`define DCT_RST8    8'h00
`define DCT_RST4    4'h0
`define DCT_RST2    2'h0
`endif

// >>> core/dct_pkg.sv
// Purpose: types shared by the dual counter/timer unit
// Assumes: nothing
// Notes:   mode codes follow the two-bit mode-select field
package dct_pkg;
    typedef enum logic [1:0] {
        DCT_MODE13 = 2'h0,
        DCT_MODE16 = 2'h1,
        DCT_MODE8R = 2'h2,
        DCT_SPLIT  = 2'h3
    } dct_mode_e;

    // one half of the mode register
    typedef struct packed {
        logic      gate;
        logic      cs;
        dct_mode_e mode;
    } dct_cfg_s;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } dct_cnt_s;
endpackage : dct_pkg

// >>> core/dct_timer_unit.sv
// Purpose: two 16-bit counter/timers with four modes behind a wishbone slave
// Assumes: one clock; pins are asynchronous and are synchronised here
// Notes:   what this block does is listed below
// What this block does
// - each timer count is 16 bits, written and read as low and high byte
// - counter select 1: count falling edges of the synchronised event pin
// - event edges up to a quarter of the clock rate are counted
// - counter select 0: clock select 1 uses every clock, 0 prescaled ticks
// - timer runs only when run set and gate off or gate input active; split high byte ignores gate, timer one while zero splits ignores both
// - timer one uses second gate input with its own polarity
// - setting run leaves the count untouched
// - 13-bit mode: high byte upper 8, low bits 4..0; bits 7..5 unused
// - 13-bit wrap sets overflow flag and may raise an interrupt
// - 16-bit mode uses all sixteen bits, otherwise like 13-bit
// - auto-reload: low counts, wrap sets flag and reloads from high
// - split: timer zero low byte is an 8-bit timer on zero's controls
// - split: high byte timer only, runs on one's run bit, sets one's flag
// - split: timer one runs without event clock or flag, still pulses out
// - timer one stops in split mode, runs in others while zero splits
// - each timer has its own mode field and configuration bits
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "dct_consts.svh"

module dct_timer_unit
    import dct_pkg::*;
(
    input  wire logic        clk_in,                 // 50 MHz clock
    input  wire logic        rst_b_in,               // async reset, low
    input  wire logic        wb_cyc_in,              // bus cycle
    input  wire logic        wb_stb_in,              // strobe
    input  wire logic        wb_we_in,               // write enable
    input  wire logic [7:0]  wb_adr_in,              // byte address
    input  wire logic [3:0]  wb_sel_in,              // byte selects
    input  wire logic [31:0] wb_dat_in,              // write data
    output logic      [31:0] wb_dat_out,             // read data
    output logic             wb_ack_out,             // acknowledge
    input  wire logic        timer_zero_event_pin_in, // event pin 0
    input  wire logic        timer_one_event_pin_in, // event pin 1
    input  wire logic        gate_zero_input_in,     // gate input 0
    input  wire logic        gate_one_input_in,      // gate input 1
    output logic             irq_out,                // level interrupt
    output logic             t0_ovf_out,             // timer zero wrap pulse
    output logic             t1_ovf_out              // timer one wrap pulse
);

////////////////////////////////////////////////////////////////////////
// step one count by one in the given mode; top bit is the wrap

function automatic logic [16:0] dct_step(input dct_mode_e m,
                                         input logic [15:0] c);
    logic [16:0] r;
    logic [13:0] s13;
    logic [8:0]  s8;
    r   = {1'b0, c};
    s13 = {1'b0, c[15:8], c[4:0]} + 14'h0001;
    s8  = {1'b0, c[7:0]} + 9'h001;
    case (m)
        DCT_MODE13: r = {s13[13], s13[12:5], c[7:5], s13[4:0]};
        DCT_MODE16: r = {1'b0, c} + 17'h00001;
        DCT_MODE8R: r = {s8[8], c[15:8],
                         (s8[8] ? c[15:8] : s8[7:0])};
        default:    r = {1'b0, c};
    endcase
    return r;
endfunction : dct_step

function automatic logic [5:0] dct_div(input logic [1:0] s);
    logic [5:0] d;
    case (s)
        2'h0:    d = `DCT_DIV0;
        2'h1:    d = `DCT_DIV1;
        2'h2:    d = `DCT_DIV2;
        default: d = `DCT_DIV3;
    endcase
    return d;
endfunction : dct_div

////////////////////////////////////////////////////////////////////////
// reset release

logic rst_s1_q;
logic rst_b;

always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        rst_s1_q <= 1'b0;
        rst_b    <= 1'b0;
    end else begin
        rst_s1_q <= 1'b1;
        rst_b    <= rst_s1_q;
    end
end

////////////////////////////////////////////////////////////////////////
// state

dct_cnt_s   t0_q;
dct_cnt_s   t1_q;
dct_cnt_s   t0_d;
dct_cnt_s   t1_d;
dct_cfg_s   cfg0_q;
dct_cfg_s   cfg1_q;
logic       run0_q;
logic       run1_q;
logic       flag0_q;
logic       flag1_q;
logic [1:0] cks_q;
logic [1:0] psel_q;
logic [1:0] pol_q;
logic [1:0] ien_q;
logic [1:0] istat_q;
logic       ack_q;
logic [5:0] pre_cnt_q;
logic       pre_tick_q;
logic [1:0] ev_s1_q;
logic [1:0] ev_s2_q;
logic [1:0] ev_s3_q;
logic [1:0] gt_s1_q;
logic [1:0] gt_s2_q;

////////////////////////////////////////////////////////////////////////
// bus decode

logic       acc;
logic       wr;
logic       rd;
logic [7:0] wd;

assign acc = wb_cyc_in & wb_stb_in & ~ack_q;
assign wr  = acc & wb_we_in & wb_sel_in[0];
assign rd  = acc & ~wb_we_in;
assign wd  = wb_dat_in[7:0];

always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
        ack_q <= 1'b0;
    end else begin
        ack_q <= acc;
    end
end

////////////////////////////////////////////////////////////////////////
// pin synchronisers and edge detect

always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
        ev_s1_q <= `DCT_RST2;
        ev_s2_q <= `DCT_RST2;
        ev_s3_q <= `DCT_RST2;
        gt_s1_q <= `DCT_RST2;
        gt_s2_q <= `DCT_RST2;
    end else begin
        ev_s1_q <= {timer_one_event_pin_in, timer_zero_event_pin_in};
        ev_s2_q <= ev_s1_q;
        ev_s3_q <= ev_s2_q;
        gt_s1_q <= {gate_one_input_in, gate_zero_input_in};
        gt_s2_q <= gt_s1_q;
    end
end

logic [1:0] ev_fall;
logic [1:0] gate_ok;

assign ev_fall = ev_s3_q & ~ev_s2_q;
assign gate_ok = ~(gt_s2_q ^ pol_q);

////////////////////////////////////////////////////////////////////////
// prescaler

always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
        pre_cnt_q  <= 6'h00;
        pre_tick_q <= 1'b0;
    end else if (pre_cnt_q >= dct_div(psel_q) - 6'h01) begin
        pre_cnt_q  <= 6'h00;
        pre_tick_q <= 1'b1;
    end else begin
        pre_cnt_q  <= pre_cnt_q + 6'h01;
        pre_tick_q <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
// count paths

logic tk0;
logic tk0t;
logic tk1;
logic tk1t;
logic en0;
logic en1;
logic ov0;
logic ovh;
logic ov1;
logic split0;

assign split0 = (cfg0_q.mode == DCT_SPLIT);
assign tk0t   = cks_q[0] | pre_tick_q;
assign tk1t   = cks_q[1] | pre_tick_q;
assign tk0    = cfg0_q.cs ? ev_fall[0] : tk0t;
assign tk1    = cfg1_q.cs ? ev_fall[1] : tk1t;
assign en0    = run0_q & (~cfg0_q.gate | gate_ok[0]) & tk0;

always_comb begin
    logic [16:0] s;
    logic [8:0]  h;
    s    = 17'h00000;
    h    = 9'h000;
    t0_d = t0_q;
    t1_d = t1_q;
    ov0  = 1'b0;
    ovh  = 1'b0;
    ov1  = 1'b0;
    en1  = 1'b0;
    if (split0) begin
        if (en0) begin
            h       = {1'b0, t0_q.lo} + 9'h001;
            t0_d.lo = h[7:0];
            ov0     = h[8];
        end
        if (run1_q & tk1t) begin
            h       = {1'b0, t0_q.hi} + 9'h001;
            t0_d.hi = h[7:0];
            ovh     = h[8];
        end
    end else if (en0) begin
        s    = dct_step(cfg0_q.mode, t0_q);
        t0_d = s[15:0];
        ov0  = s[16];
    end
    if (cfg1_q.mode != DCT_SPLIT) begin
        if (split0) begin
            en1 = tk1t;
        end else begin
            en1 = run1_q & (~cfg1_q.gate | gate_ok[1]) & tk1;
        end
    end
    if (en1) begin
        s    = dct_step(cfg1_q.mode, t1_q);
        t1_d = s[15:0];
        ov1  = s[16];
    end
end

logic set1;
assign set1 = split0 ? ovh : ov1;

////////////////////////////////////////////////////////////////////////
// count registers; a bus write wins over a step in that cycle

always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
        t0_q <= {`DCT_RST8, `DCT_RST8};
    end else begin
        t0_q.lo <= (wr && wb_adr_in == `DCT_A_T0LO) ? wd : t0_d.lo;
        t0_q.hi <= (wr && wb_adr_in == `DCT_A_T0HI) ? wd : t0_d.hi;
    end
end

always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
        t1_q <= {`DCT_RST8, `DCT_RST8};
    end else begin
        t1_q.lo <= (wr && wb_adr_in == `DCT_A_T1LO) ? wd : t1_d.lo;
        t1_q.hi <= (wr && wb_adr_in == `DCT_A_T1HI) ? wd : t1_d.hi;
    end
end

////////////////////////////////////////////////////////////////////////
// run and flag register; hardware set wins over software clear

always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
        run0_q  <= 1'b0;
        run1_q  <= 1'b0;
        flag0_q <= 1'b0;
        flag1_q <= 1'b0;
    end else begin
        if (wr && wb_adr_in == `DCT_A_RUN) begin
            run0_q <= wd[`DCT_B_RUN0];
            run1_q <= wd[`DCT_B_RUN1];
        end
        if (ov0) begin
            flag0_q <= 1'b1;
        end else if (wr && wb_adr_in == `DCT_A_RUN) begin
            flag0_q <= wd[`DCT_B_OVF0];
        end
        if (set1) begin
            flag1_q <= 1'b1;
        end else if (wr && wb_adr_in == `DCT_A_RUN) begin
            flag1_q <= wd[`DCT_B_OVF1];
        end
    end
end

////////////////////////////////////////////////////////////////////////
// configuration registers

always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
        cfg0_q <= `DCT_RST4;
        cfg1_q <= `DCT_RST4;
        cks_q  <= `DCT_RST2;
        psel_q <= `DCT_RST2;
        pol_q  <= `DCT_RST2;
        ien_q  <= `DCT_RST2;
    end else if (wr) begin
        if (wb_adr_in == `DCT_A_MODE) begin
            cfg0_q <= wd[3:0];
            cfg1_q <= wd[7:4];
        end
        if (wb_adr_in == `DCT_A_CLK) begin
            cks_q  <= wd[`DCT_B_CKS1:`DCT_B_CKS0];
            psel_q <= wd[`DCT_B_PSLO+1:`DCT_B_PSLO];
        end
        if (wb_adr_in == `DCT_A_GCFG) begin
            pol_q <= wd[1:0];
        end
        if (wb_adr_in == `DCT_A_IEN) begin
            ien_q <= wd[1:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////
// interrupt status: set on flag events, cleared by its read

logic rd_ist;
assign rd_ist = rd && wb_adr_in == `DCT_A_ISTAT;

always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
        istat_q <= `DCT_RST2;
        irq_out <= 1'b0;
    end else begin
        istat_q <= {set1, ov0} | (rd_ist ? 2'h0 : istat_q);
        irq_out <= |(istat_q & ien_q);
    end
end

always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
        t0_ovf_out <= 1'b0;
        t1_ovf_out <= 1'b0;
    end else begin
        t0_ovf_out <= ov0;
        t1_ovf_out <= ov1;
    end
end

////////////////////////////////////////////////////////////////////////
// read mux

logic [7:0] rdat;

always_comb begin
    case (wb_adr_in)
        `DCT_A_T0LO:  rdat = t0_q.lo;
        `DCT_A_T0HI:  rdat = t0_q.hi;
        `DCT_A_T1LO:  rdat = t1_q.lo;
        `DCT_A_T1HI:  rdat = t1_q.hi;
        `DCT_A_RUN:   rdat = {4'h0, flag1_q, run1_q, flag0_q, run0_q};
        `DCT_A_MODE:  rdat = {cfg1_q, cfg0_q};
        `DCT_A_CLK:   rdat = {4'h0, psel_q, cks_q};
        `DCT_A_GCFG:  rdat = {6'h00, pol_q};
        `DCT_A_IEN:   rdat = {6'h00, ien_q};
        `DCT_A_ISTAT: rdat = {6'h00, istat_q};
        default:      rdat = 8'h00;
    endcase
end

always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
        wb_ack_out <= 1'b0;
        wb_dat_out <= 32'h00000000;
    end else begin
        wb_ack_out <= acc;
        wb_dat_out <= rd ? {24'h000000, rdat} : 32'h00000000;
    end
end

endmodule : dct_timer_unit
